// ===== dv/kpi_assertions.sv
// checker of port behaviour for the keyboard pin interrupt block
`timescale 1ns/1ps
module kpi_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [5:0] i_keypad_input_pins,
    input wire logic i_break_state,
    input wire logic i_vector_fetch,
    input wire logic o_irq,
    input wire logic [5:0] o_pullup_en,
    input wire logic [5:0] o_pulldown_en,
    input wire logic o_wakeup_interrupt_enable
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic acc;
    // access phase not yet answered
    assign acc = i_psel && i_penable && !o_pready;
    a_ready_wait: assert property (acc |=> o_pready) else $error("no ready after access");
    a_ready_single: assert property (o_pready |=> !o_pready) else $error("ready held too long");
    a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    a_err_unmapped: assert property (acc && !(i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})
        |=> o_pslverr && o_pready) else $error("unmapped access not refused");
    a_ack_reads_zero: assert property (o_pready && i_paddr == 12'h000 |-> !o_prdata[2])
        else $error("ack bit read as one");
    a_pull_exclusive: assert property ((o_pullup_en & o_pulldown_en) == 6'h00) else $error("both pulls on");
    // pulls move two cycles after the accepted write, once the enable register has settled
    a_pull_stable: assert property ($changed(o_pullup_en) || $changed(o_pulldown_en) |->
        $past(acc && i_pwrite, 2)) else $error("pull changed without write");
    a_mask_blocks_irq: assert property (acc && i_pwrite && i_paddr == 12'h000
        && i_pwdata[1] |=> ##1 !o_irq) else $error("masked request reached output");
    a_reset_clears: assert property ($rose(i_rst_n) |-> !o_irq && o_pullup_en == 6'h00)
        else $error("request survived reset");
    c_fetch: cover property (i_vector_fetch && o_irq);
    c_irq: cover property ($rose(o_irq));
    c_err: cover property (o_pslverr);
endmodule
bind kpi_keyboard_pin_interrupt kpi_checker u_kpi_checker (.*);

// ===== dv/kpi_keypad_model.sv
// keypad switch model driving the shared pins
`timescale 1ns/1ps
module kpi_keypad_model (
    input wire logic i_sys_clk,
    input wire logic [5:0] i_press,
    input wire logic [5:0] i_pullup_en,
    input wire logic [5:0] i_pulldown_en,
    output logic [5:0] o_pins
);
    initial o_pins = 6'h00;
    // closed switch drives against the pull; an unpulled pin floats and toggles
    // an unknown pull before reset counts as none, so the pins never go unknown
    always @(posedge i_sys_clk) begin
        for (int i = 0; i < 6; i++) begin
            o_pins[i] <= (i_pullup_en[i] === 1'b1) ? !i_press[i] :
                         ((i_pulldown_en[i] === 1'b1) ? i_press[i] : !o_pins[i]);
        end
    end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the keyboard pin interrupt block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [5:0] press = 6'h00;
    logic brk = 1'b0;
    logic vf = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, wk, err;
    logic [5:0] pins, pu, pd;
    logic [7:0] q;
    int num_errors = 0;
    int total_checks = 0;
    kpi_keyboard_pin_interrupt u_kpi_keyboard_pin_interrupt (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_keypad_input_pins(pins), .i_break_state(brk),
        .i_vector_fetch(vf), .o_irq(irq), .o_pullup_en(pu), .o_pulldown_en(pd), .o_wakeup_interrupt_enable(wk));
    kpi_keypad_model u_kpi_keypad_model (.i_sys_clk(clk), .i_press(press), .i_pullup_en(pu),
        .i_pulldown_en(pd), .o_pins(pins));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; pready, read data and error are taken at the rising edge, then released
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwr <= w;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        chk(q, e);
    endtask
    task automatic pr(input logic [5:0] p);
        @(posedge clk);
        press <= p;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h000, 8'h00);
        rd(12'h004, 8'h00);
        rd(12'h008, 8'h00);
        rd(12'h00C, 8'h00);
        rd(12'h010, 8'h00);
        chk({7'h00, err}, 8'h01);
        $display("test reset done");
        apb(12'h000, 1'b1, 8'h02);
        apb(12'h008, 1'b1, 8'h0F);
        apb(12'h004, 1'b1, 8'h7D);
        pr(6'h00);
        apb(12'h000, 1'b1, 8'h06);
        apb(12'h000, 1'b1, 8'h00);
        rd(12'h004, 8'h7D);
        chk({7'h00, wk}, 8'h01);
        rd(12'h008, 8'h0F);
        chk({2'b00, pd}, 8'h0D);
        chk({2'b00, pu}, 8'h30);
        rd(12'h000, 8'h00);
        pr(6'h01);
        rd(12'h000, 8'h08);
        @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        apb(12'h000, 1'b1, 8'h02);
        rd(12'h000, 8'h0A);
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        apb(12'h000, 1'b1, 8'h06);
        rd(12'h000, 8'h02);
        apb(12'h000, 1'b1, 8'h00);
        pr(6'h21);
        rd(12'h000, 8'h00);
        pr(6'h02);
        rd(12'h000, 8'h00);
        pr(6'h00);
        $display("test edge done");
        apb(12'h000, 1'b1, 8'h01);
        pr(6'h04);
        rd(12'h000, 8'h09);
        apb(12'h000, 1'b1, 8'h05);
        rd(12'h000, 8'h09);
        pr(6'h00);
        rd(12'h000, 8'h01);
        pr(6'h08);
        pr(6'h00);
        rd(12'h000, 8'h09);
        apb(12'h000, 1'b1, 8'h05);
        rd(12'h000, 8'h01);
        apb(12'h000, 1'b1, 8'h00);
        pr(6'h08);
        @(posedge clk);
        vf <= 1'b1;
        @(posedge clk);
        vf <= 1'b0;
        rd(12'h000, 8'h00);
        pr(6'h10);
        @(posedge clk);
        brk <= 1'b1;
        apb(12'h000, 1'b1, 8'h04);
        rd(12'h000, 8'h08);
        @(posedge clk);
        brk <= 1'b0;
        apb(12'h000, 1'b1, 8'h04);
        rd(12'h000, 8'h00);
        apb(12'h00C, 1'b1, 8'h01);
        pr(6'h00);
        pr(6'h10);
        @(posedge clk);
        brk <= 1'b1;
        apb(12'h000, 1'b1, 8'h04);
        @(posedge clk);
        brk <= 1'b0;
        rd(12'h000, 8'h00);
        $display("test level and break done");
        apb(12'h000, 1'b1, 8'h01);
        pr(6'h00);
        pr(6'h10);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h000, 8'h00);
        $display("test second reset done");
        report_and_stop();
    end
endmodule

// ===== src/kpi_keyboard_pin_interrupt.sv
// top of the keyboard pin interrupt block with apb register slave
//
// Operation
// - with break-clear enabled, software clears status during break; it stays cleared.
// - with break-clear disabled, accesses during break leave status bits unchanged.
// - step one before break holds status in break; step two afterward clears.
// - each pin enabled and polarised alone; pull-up for low, pull-down for high.
// - read-only pending flag reads 1 when request pending, else 0.
// - writing 1 to acknowledge clears request; acknowledge always reads 0.
// - mask bit 1 blocks the request output; 0 lets it through.
// - sensitivity 1 means edges and levels; 0 means edges only.
// - pin enable 1 lets the pin latch requests; 0 ignores it.
// - polarity 1 selects high or rising; 0 selects low or falling.
// - wake-up enable bit has no effect on keyboard detection.
// - edge-only: new edge ignored while another enabled pin stays asserted.
// - edge-and-level: clears only after pins deassert and acknowledge, any order.
// - vector fetch acknowledges like writing the acknowledge bit, and also during break with break-clear disabled.
// - reset clears pending request and sensitivity even with pins asserted.
`timescale 1ns/1ps
module kpi_keyboard_pin_interrupt (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [5:0] i_keypad_input_pins,
    input wire logic i_break_state,
    input wire logic i_vector_fetch,
    output logic o_irq,
    output logic [5:0] o_pullup_en,
    output logic [5:0] o_pulldown_en,
    output logic o_wakeup_interrupt_enable
);
    // ------------------------------------------------------------
    // registers and pin detection
    // ------------------------------------------------------------
    logic request_mask_ff;
    logic trigger_sensitivity_ff;
    logic [5:0] pin_enable_ff;
    logic [5:0] pin_polarity_ff;
    logic wakeup_ff;
    logic break_clear_enable_ff;
    logic latch_ff;
    logic ack_pending_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [5:0] pullup_ff;
    logic [5:0] pulldown_ff;
    logic nxt_latch;
    logic nxt_ack_pending;
    logic any_asserted;
    logic any_edge;
    logic block_edge;
    logic sw_ack;
    logic ack_now;
    logic clear_allowed;
    logic wr_access;
    logic rd_access;
    logic addr_hit;
    logic wr_status;
    logic wr_enable;
    logic wr_polarity;
    logic wr_break;
    logic [31:0] nxt_rdata;
    kpi_pin_if pin_bus ();

    // configuration and raw pins go to the per-pin detector
    assign pin_bus.enable = pin_enable_ff;
    assign pin_bus.polarity = pin_polarity_ff;
    assign pin_bus.pins = i_keypad_input_pins;

    // level and edge detection for all six pins
    kpi_pin_detect u_detect (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .pin_bus(pin_bus)
    );

    // ------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------
    // a transfer is taken once, in the first access cycle; pready_ff blocks the repeat
    assign wr_access = i_psel && i_penable && i_pwrite && !pready_ff;
    assign rd_access = i_psel && i_penable && !i_pwrite && !pready_ff;
    assign addr_hit = (i_paddr == kpi_pkg::ADDR_STATUS_CONTROL) || (i_paddr == kpi_pkg::ADDR_PIN_ENABLE) ||
                      (i_paddr == kpi_pkg::ADDR_PIN_POLARITY) || (i_paddr == kpi_pkg::ADDR_BREAK_CONTROL);

    // ------------------------------------------------------------
    // latch logic
    // ------------------------------------------------------------
    // status clearing is allowed outside break or with break-clear enabled
    assign clear_allowed = !i_break_state || break_clear_enable_ff;
    assign sw_ack = wr_access && (i_paddr == kpi_pkg::ADDR_STATUS_CONTROL) && i_pstrb[0] &&
                    i_pwdata[kpi_pkg::SC_ACK_BIT];
    assign ack_now = (sw_ack && clear_allowed) || i_vector_fetch;
    // any enabled pin at its active level, and any new active edge this cycle
    assign any_asserted = |pin_bus.asserted;
    assign any_edge = |pin_bus.edge_hit;
    // an edge is masked when some other enabled pin was already asserted
    assign block_edge = |((pin_bus.asserted & ~pin_bus.edge_hit));

    // next latch state: a set wins over a simultaneous clear
    always_comb begin
        nxt_latch = latch_ff;
        nxt_ack_pending = ack_pending_ff;
        if (trigger_sensitivity_ff) begin
            // edge and level: clear once pins deassert and an acknowledge was seen
            if (ack_now) begin
                nxt_ack_pending = 1'b1;
            end
            if (latch_ff && (ack_now || ack_pending_ff) && !any_asserted) begin
                nxt_latch = 1'b0;
                nxt_ack_pending = 1'b0;
            end
            if (any_edge) begin
                nxt_latch = 1'b1;
                nxt_ack_pending = 1'b0;
            end
        end else begin
            nxt_ack_pending = 1'b0;
            if (ack_now) begin
                nxt_latch = 1'b0;
            end
            if (any_edge && !block_edge) begin
                nxt_latch = 1'b1;
            end
        end
    end

    // keyboard latch, cleared by reset regardless of pins
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_ff <= 1'b0;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // acknowledge remembered in edge-and-level mode until every enabled pin is back at rest
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_pending_ff <= 1'b0;
        end else begin
            ack_pending_ff <= nxt_ack_pending;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // one write strobe per register; every field sits in byte lane 0
    assign wr_status = wr_access && i_pstrb[0] && (i_paddr == kpi_pkg::ADDR_STATUS_CONTROL);
    assign wr_enable = wr_access && i_pstrb[0] && (i_paddr == kpi_pkg::ADDR_PIN_ENABLE);
    assign wr_polarity = wr_access && i_pstrb[0] && (i_paddr == kpi_pkg::ADDR_PIN_POLARITY);
    assign wr_break = wr_access && i_pstrb[0] && (i_paddr == kpi_pkg::ADDR_BREAK_CONTROL);

    // request mask: configuration, not status, so the break guard leaves it writable
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            request_mask_ff <= kpi_pkg::RST_MASK;
        end else if (wr_status) begin
            request_mask_ff <= i_pwdata[kpi_pkg::SC_MASK_BIT];
        end
    end

    // trigger sensitivity, cleared by reset together with the latch
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trigger_sensitivity_ff <= kpi_pkg::RST_SENS;
        end else if (wr_status) begin
            trigger_sensitivity_ff <= i_pwdata[kpi_pkg::SC_SENS_BIT];
        end
    end

    // pin enables, one bit per pin
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_enable_ff <= kpi_pkg::RST_PIN_ENABLE;
        end else if (wr_enable) begin
            pin_enable_ff <= i_pwdata[5:0];
        end
    end

    // wake-up enable only shares the register; the detector never sees it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wakeup_ff <= kpi_pkg::RST_WAKEUP;
        end else if (wr_enable) begin
            wakeup_ff <= i_pwdata[kpi_pkg::EN_WAKEUP_BIT];
        end
    end

    // pin polarities, one bit per pin
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_polarity_ff <= kpi_pkg::RST_PIN_POLARITY;
        end else if (wr_polarity) begin
            pin_polarity_ff <= i_pwdata[5:0];
        end
    end

    // break-clear enable of the system integration unit, default off
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            break_clear_enable_ff <= kpi_pkg::RST_BREAK_CLEAR;
        end else if (wr_break) begin
            break_clear_enable_ff <= i_pwdata[kpi_pkg::BRK_CLEAR_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // read mux and apb answer
    // ------------------------------------------------------------
    // read data; acknowledge bit always reads zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        unique case (i_paddr)
            kpi_pkg::ADDR_STATUS_CONTROL: begin
                nxt_rdata[kpi_pkg::SC_PENDING_BIT] = latch_ff;
                nxt_rdata[kpi_pkg::SC_MASK_BIT] = request_mask_ff;
                nxt_rdata[kpi_pkg::SC_SENS_BIT] = trigger_sensitivity_ff;
            end
            kpi_pkg::ADDR_PIN_ENABLE: begin
                nxt_rdata[5:0] = pin_enable_ff;
                nxt_rdata[kpi_pkg::EN_WAKEUP_BIT] = wakeup_ff;
            end
            kpi_pkg::ADDR_PIN_POLARITY: begin
                nxt_rdata[5:0] = pin_polarity_ff;
            end
            kpi_pkg::ADDR_BREAK_CONTROL: begin
                nxt_rdata[kpi_pkg::BRK_CLEAR_EN_BIT] = break_clear_enable_ff;
            end
            default: begin
            end
        endcase
    end

    // one wait state: pready rises in the second access cycle and stands one cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= (wr_access || rd_access);
        end
    end

    // unmapped addresses answer with an error; their writes miss every strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= (wr_access || rd_access) && !addr_hit;
        end
    end

    // read data stands with pready only, so a stale value never leaks onto the bus
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_ff <= 32'h00000000;
        end else begin
            prdata_ff <= rd_access ? nxt_rdata : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    // request output follows the next latch value so it keeps step with the pending flag
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_latch && !request_mask_ff;
        end
    end

    // pull devices follow enable and polarity; a disabled pin gets neither
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pullup_ff <= 6'h00;
            pulldown_ff <= 6'h00;
        end else begin
            pullup_ff <= pin_enable_ff & ~pin_polarity_ff;
            pulldown_ff <= pin_enable_ff & pin_polarity_ff;
        end
    end

    // ------------------------------------------------------------
    // port drive
    // ------------------------------------------------------------
    // every output comes straight from a flip-flop
    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_irq = irq_ff;
    assign o_pullup_en = pullup_ff;
    assign o_pulldown_en = pulldown_ff;
    assign o_wakeup_interrupt_enable = wakeup_ff;
endmodule

// ===== src/kpi_pin_detect.sv
// per-pin asserted-level and active-edge detection
`timescale 1ns/1ps
module kpi_pin_detect (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    kpi_pin_if.det pin_bus
);
    logic [5:0] lvl_ff;
    logic [5:0] nxt_lvl;

    // asserted level follows polarity, gated by enable
    always_comb begin
        nxt_lvl = pin_bus.enable & ~(pin_bus.pins ^ pin_bus.polarity);
    end

    // previous asserted level, for edge detection
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_ff <= 6'h00;
        end else begin
            lvl_ff <= nxt_lvl;
        end
    end

    assign pin_bus.asserted = nxt_lvl;
    assign pin_bus.edge_hit = nxt_lvl & ~lvl_ff;
endmodule

// ===== src/kpi_pin_if.sv
// interface carrying per-pin configuration and detection results between top and pin detector
`timescale 1ns/1ps
interface kpi_pin_if;
    logic [5:0] enable;
    logic [5:0] polarity;
    logic [5:0] pins;
    logic [5:0] asserted;
    logic [5:0] edge_hit;
    modport top (output enable, output polarity, output pins, input asserted, input edge_hit);
    modport det (input enable, input polarity, input pins, output asserted, output edge_hit);
endinterface

// ===== src/kpi_pkg.sv
// package of register map, field positions and reset values for the keyboard pin interrupt block
package kpi_pkg;
    localparam int NUM_PINS = 6;
    localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_PIN_ENABLE = 12'h004;
    localparam logic [11:0] ADDR_PIN_POLARITY = 12'h008;
    localparam logic [11:0] ADDR_BREAK_CONTROL = 12'h00C;
    localparam int SC_PENDING_BIT = 3;
    localparam int SC_ACK_BIT = 2;
    localparam int SC_MASK_BIT = 1;
    localparam int SC_SENS_BIT = 0;
    localparam int EN_WAKEUP_BIT = 6;
    localparam int BRK_CLEAR_EN_BIT = 0;
    localparam logic RST_MASK = 1'b0;
    localparam logic RST_SENS = 1'b0;
    localparam logic RST_WAKEUP = 1'b0;
    localparam logic RST_BREAK_CLEAR = 1'b0;
    localparam logic [5:0] RST_PIN_ENABLE = 6'h00;
    localparam logic [5:0] RST_PIN_POLARITY = 6'h00;
endpackage
